// *** cmt_consts.svh ***
// Constants for the clock operating-mode sequencer
// What this block does
// RULE_01: Software clears stop-detect enable before low-power moves
// RULE_02: Sub clock may feed timers in PLL mode
// RULE_03: PLL mode only entered from/left to high-speed
// RULE_04: Software sets divide-by-8 before on-chip to high-speed
// RULE_05: Leaving stop forces divide-by-8
// RULE_06: Main oscillator stop write forces divide-by-8
// RULE_07: Low-speed entry needs running sub clock
// RULE_08: Divider and sub clock changeable within a mode
// RULE_09: Low power goes only to low-speed, stop, wait
// RULE_10: On-chip low power goes only to on-chip, stop, wait
// RULE_11: Stop bit enters stop; wait instruction enters wait
// RULE_12: Hardware interrupt wakes from stop or wait
// RULE_13: Divider encoding: 1, 2, 4, 16; forced bit gives 8
// RULE_14: Clock source chosen by sub, on-chip, PLL bits
// RULE_15: Disallowed mode changes are ignored entirely
// RULE_16: Clock source switching is glitch-free
`ifndef CMT_CONSTS_SVH
`define CMT_CONSTS_SVH

// Control word width and reset value (divide-by-8 forced, main clock)
`define CMT_CTRL_W      11
`define CMT_CTRL_RST    11'h200

// Divider select codes
`define CMT_DSEL_1      2'h0
`define CMT_DSEL_2      2'h1
`define CMT_DSEL_4      2'h2
`define CMT_DSEL_16     2'h3

// Divider ratios as shown on the ratio output
`define CMT_RATIO_1     5'h01
`define CMT_RATIO_2     5'h02
`define CMT_RATIO_4     5'h04
`define CMT_RATIO_8     5'h08
`define CMT_RATIO_16    5'h10

// One-hot clock source gate positions
`define CMT_SRC_W       4
`define CMT_SRC_MAIN    4'h1
`define CMT_SRC_SUB     4'h2
`define CMT_SRC_PLL     4'h4
`define CMT_SRC_ONCHIP  4'h8
`define CMT_SRC_NONE    4'h0

// Dead time count; all gates stay closed one cycle longer than this between two sources
`define CMT_DEAD_CYC    3

`endif

// *** cmt_pkg.sv ***
// Types shared by the clock mode sequencer
package cmt_pkg;
   // Operating modes
   typedef enum logic [2:0] {
      CMT_HMS, CMT_LOWSPD, CMT_LOWPWR, CMT_PLL,
      CMT_OCO, CMT_OCO_LP, CMT_STOP, CMT_WAIT
   } cmt_mode_e;

   // Software control bits
   typedef struct packed {
      logic osc_stop_detect_enable;
      logic div8_force_bit;
      logic main_osc_stop_bit;
      logic sub_osc_on_bit;
      logic sysclk_sub_select;
      logic stop_entry_bit;
      logic pll_route_select;
      logic cpu_div_select_hi;
      logic cpu_div_select_lo;
      logic onchip_osc_select;
      logic pll_enable_bit;
   } cmt_ctrl_s;
endpackage

// *** cmt_clk_switch.sv ***
// Break-before-make gate sequencer for the system clock sources
`include "cmt_consts.svh"
module cmt_clk_switch import cmt_pkg::*; #(
   parameter int DEAD = `CMT_DEAD_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic [`CMT_SRC_W-1:0] src_req,
   output logic      [`CMT_SRC_W-1:0] gate_r
);
   logic [3:0] dead_r;   // Remaining closed cycles

   // RULE_16 break before make
   // Close the old gate, hold all closed, then open the new one
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gate_r <= `CMT_SRC_MAIN;
         dead_r <= 4'h0;
      end else if (src_req != gate_r) begin
         if (gate_r != `CMT_SRC_NONE) begin
            // Old source off first
            gate_r <= `CMT_SRC_NONE;
            dead_r <= 4'(DEAD);
         end else if (dead_r != 4'h0) begin
            // Still settling
            dead_r <= dead_r - 4'h1;
         end else begin
            // New source on
            gate_r <= src_req;
         end
      end
   end

   // RULE_16 no overlap
   property p_gate_clean;
      @(posedge clk) disable iff (!rstn)
      (gate_r != `CMT_SRC_NONE) && ($past(gate_r) != gate_r) |->
         $past(gate_r) == `CMT_SRC_NONE && $past(gate_r, 2) == `CMT_SRC_NONE;
   endproperty
   a_gate_clean: assert property (p_gate_clean) else $error("clock gate opened without dead time"); // RULE_16

   property p_gate_onehot;
      @(posedge clk) disable iff (!rstn) $onehot0(gate_r);
   endproperty
   a_gate_onehot: assert property (p_gate_onehot) else $error("two clock gates open"); // RULE_16
endmodule

// *** cmt_ctrl.sv ***
// Clock operating-mode sequencer: transition checks, divider, source select
`include "cmt_consts.svh"
module cmt_ctrl import cmt_pkg::*; #(
   parameter int DEAD = `CMT_DEAD_CYC
) (
   input  wire logic                  clk,
   input  wire logic                  rstn,
   input  wire logic                  ctrl_wr,
   input  wire cmt_ctrl_s             ctrl_wdata,
   input  wire logic                  wait_instr,
   input  wire logic                  hw_irq,
   output cmt_mode_e                  mode_r,
   output cmt_ctrl_s                  ctrl_r,
   output logic      [4:0]            cpu_div_ratio_r,
   output logic                       cpu_clk_run_r,
   output logic                       sub_timer_clk_en_r,
   output logic                       refused_r,
   output logic      [`CMT_SRC_W-1:0] src_gate_r
);
   logic      irq_meta_r;   // Synchroniser first stage
   logic      irq_sync_r;   // Synchroniser second stage
   logic      irq_prev_r;   // Previous synchronised level
   logic      irq_rise;     // Wake event
   cmt_mode_e ret_mode_r;   // Mode to resume after stop or wait
   cmt_mode_e tgt;          // Mode the written bits ask for
   logic      halted;       // In stop or wait
   logic      wake;         // Interrupt while halted
   logic      wr_ok;        // Write accepted
   logic      wait_ok;      // Wait accepted
   cmt_ctrl_s ctrl_nxt;     // Control word after an accepted write
   logic [`CMT_SRC_W-1:0] src_req;   // Requested clock source

   // RULE_14 source priority
   // Mode that a control word selects
   function automatic cmt_mode_e tgt_mode(input cmt_ctrl_s c);
      if (c.stop_entry_bit)
         tgt_mode = CMT_STOP;
      else if (c.sysclk_sub_select)
         tgt_mode = c.main_osc_stop_bit ? CMT_LOWPWR : CMT_LOWSPD;
      else if (c.onchip_osc_select)
         tgt_mode = c.main_osc_stop_bit ? CMT_OCO_LP : CMT_OCO;
      else if (c.pll_enable_bit && c.pll_route_select)
         tgt_mode = CMT_PLL;
      else
         tgt_mode = CMT_HMS;
   endfunction

   // Transition matrix check
   function automatic logic allowed(input cmt_mode_e cur, input cmt_mode_e nxt, input logic sub_run);
      logic ok;
      ok = 1'b0;
      case (cur)
         // RULE_03 high-speed to PLL; RULE_07 low-speed needs sub clock
         CMT_HMS:    ok = (nxt == CMT_HMS) || (nxt == CMT_PLL) || (nxt == CMT_OCO) ||
                          (nxt == CMT_STOP) || (nxt == CMT_WAIT) || (nxt == CMT_LOWSPD && sub_run);
         CMT_LOWSPD: ok = (nxt != CMT_PLL) && (nxt != CMT_OCO_LP);
         // RULE_09 low power exits
         CMT_LOWPWR: ok = (nxt == CMT_LOWPWR) || (nxt == CMT_LOWSPD) || (nxt == CMT_STOP) ||
                          (nxt == CMT_WAIT);
         // RULE_03 PLL only back to high-speed
         CMT_PLL:    ok = (nxt == CMT_PLL) || (nxt == CMT_HMS);
         CMT_OCO:    ok = (nxt != CMT_PLL) && (nxt != CMT_LOWPWR) && (nxt != CMT_LOWSPD || sub_run);
         // RULE_10 on-chip low power exits
         CMT_OCO_LP: ok = (nxt == CMT_OCO_LP) || (nxt == CMT_OCO) || (nxt == CMT_STOP) ||
                          (nxt == CMT_WAIT);
         default:    ok = 1'b0;
      endcase
      allowed = ok;
   endfunction

   // RULE_13 divider encoding
   function automatic logic [4:0] div_ratio(input cmt_ctrl_s c);
      if (c.div8_force_bit)
         div_ratio = `CMT_RATIO_8;
      else
         case ({c.cpu_div_select_hi, c.cpu_div_select_lo})
            `CMT_DSEL_1: div_ratio = `CMT_RATIO_1;
            `CMT_DSEL_2: div_ratio = `CMT_RATIO_2;
            `CMT_DSEL_4: div_ratio = `CMT_RATIO_4;
            default:     div_ratio = `CMT_RATIO_16;
         endcase
   endfunction

   // Interrupt pin synchroniser and edge detect
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         irq_meta_r <= 1'b0;
         irq_sync_r <= 1'b0;
         irq_prev_r <= 1'b0;
      end else begin
         irq_meta_r <= hw_irq;
         irq_sync_r <= irq_meta_r;
         irq_prev_r <= irq_sync_r;
      end
   end
   assign irq_rise = irq_sync_r & ~irq_prev_r;

   // Request decode
   always_comb begin
      tgt      = tgt_mode(ctrl_wdata);
      halted   = (mode_r == CMT_STOP) || (mode_r == CMT_WAIT);
      // RULE_12 interrupt wakes
      wake     = halted & irq_rise;
      // RULE_15 only matrix moves pass; RULE_08 same mode allowed
      wr_ok    = ctrl_wr & ~halted & allowed(mode_r, tgt, ctrl_r.sub_osc_on_bit);
      wait_ok  = wait_instr & ~ctrl_wr & ~halted & allowed(mode_r, CMT_WAIT, ctrl_r.sub_osc_on_bit);
      ctrl_nxt = ctrl_wdata;
      // RULE_06 main stop forces divide-by-8
      if (ctrl_wdata.main_osc_stop_bit)
         ctrl_nxt.div8_force_bit = 1'b1;
      // RULE_11 stop write touches only the stop bit
      if (ctrl_wdata.stop_entry_bit) begin
         ctrl_nxt = ctrl_r;
         ctrl_nxt.stop_entry_bit = 1'b1;
      end
   end

   // Control word update
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= cmt_ctrl_s'(`CMT_CTRL_RST);
      end else if (wake && mode_r == CMT_STOP) begin
         // RULE_05 stop exit forces divide-by-8
         ctrl_r.div8_force_bit <= 1'b1;
         ctrl_r.stop_entry_bit <= 1'b0;
      end else if (wr_ok) begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // Mode state and resume target
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         mode_r     <= CMT_HMS;
         ret_mode_r <= CMT_HMS;
      end else if (wake) begin
         // RULE_12 resume prior mode
         mode_r <= ret_mode_r;
      end else if (wr_ok) begin
         // RULE_11 stop entry and any other accepted written move
         mode_r <= tgt;
         if (tgt == CMT_STOP)
            ret_mode_r <= mode_r;
      end else if (wait_ok) begin
         // RULE_11 wait entry
         mode_r     <= CMT_WAIT;
         ret_mode_r <= mode_r;
      end
   end

   // Refusal flag, one cycle per ignored request
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn)
         refused_r <= 1'b0;
      else
         refused_r <= (ctrl_wr & ~wr_ok) | (wait_instr & ~wait_ok);
   end

   // Divider ratio, CPU run and sub timer enable
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cpu_div_ratio_r    <= `CMT_RATIO_8;
         cpu_clk_run_r      <= 1'b1;
         sub_timer_clk_en_r <= 1'b0;
      end else begin
         // RULE_08 divider follows control
         cpu_div_ratio_r    <= div_ratio(ctrl_r);
         cpu_clk_run_r      <= ~halted;
         // RULE_02 sub clock usable by timers
         sub_timer_clk_en_r <= ctrl_r.sub_osc_on_bit && mode_r != CMT_STOP;
      end
   end

   // RULE_14 source per mode
   always_comb begin
      case (mode_r)
         CMT_HMS:                src_req = `CMT_SRC_MAIN;
         CMT_LOWSPD, CMT_LOWPWR: src_req = `CMT_SRC_SUB;
         CMT_PLL:                src_req = `CMT_SRC_PLL;
         CMT_OCO, CMT_OCO_LP:    src_req = `CMT_SRC_ONCHIP;
         CMT_WAIT:               src_req = src_gate_r;
         default:                src_req = `CMT_SRC_NONE;
      endcase
   end

   // Glitch-free source gate
   cmt_clk_switch #(.DEAD(DEAD)) u_switch (
      .clk     (clk),
      .rstn    (rstn),
      .src_req (src_req),
      .gate_r  (src_gate_r)
   );

   property p_pll_entry;
      @(posedge clk) disable iff (!rstn)
      mode_r == CMT_PLL && $past(mode_r) != CMT_PLL |-> $past(mode_r) == CMT_HMS;
   endproperty
   a_pll_entry: assert property (p_pll_entry) else $error("PLL entered from wrong mode"); // RULE_03

   property p_pll_exit;
      @(posedge clk) disable iff (!rstn)
      $past(mode_r) == CMT_PLL && mode_r != CMT_PLL |-> mode_r == CMT_HMS;
   endproperty
   a_pll_exit: assert property (p_pll_exit) else $error("PLL left to wrong mode"); // RULE_03

   property p_stop_exit_div8;
      @(posedge clk) disable iff (!rstn)
      mode_r == CMT_STOP ##1 mode_r != CMT_STOP |-> ctrl_r.div8_force_bit ##1 cpu_div_ratio_r == `CMT_RATIO_8;
   endproperty
   a_stop_exit_div8: assert property (p_stop_exit_div8) else $error("stop exit without divide-by-8"); // RULE_05

   property p_main_stop_div8;
      @(posedge clk) disable iff (!rstn)
      ctrl_r.main_osc_stop_bit |-> ctrl_r.div8_force_bit;
   endproperty
   a_main_stop_div8: assert property (p_main_stop_div8) else $error("main stop without divide-by-8"); // RULE_06

   property p_lowspd_sub;
      @(posedge clk) disable iff (!rstn)
      mode_r == CMT_LOWSPD && ($past(mode_r) == CMT_HMS || $past(mode_r) == CMT_OCO) |->
         $past(ctrl_r.sub_osc_on_bit);
   endproperty
   a_lowspd_sub: assert property (p_lowspd_sub) else $error("low-speed entered with sub clock off"); // RULE_07

   property p_lowpwr_dest;
      @(posedge clk) disable iff (!rstn)
      $past(mode_r) == CMT_LOWPWR && mode_r != CMT_LOWPWR |->
         mode_r inside {CMT_LOWSPD, CMT_STOP, CMT_WAIT};
   endproperty
   a_lowpwr_dest: assert property (p_lowpwr_dest) else $error("bad exit from low power"); // RULE_09

   property p_ocolp_dest;
      @(posedge clk) disable iff (!rstn)
      $past(mode_r) == CMT_OCO_LP && mode_r != CMT_OCO_LP |->
         mode_r inside {CMT_OCO, CMT_STOP, CMT_WAIT};
   endproperty
   a_ocolp_dest: assert property (p_ocolp_dest) else $error("bad exit from on-chip low power"); // RULE_10

   property p_wake;
      @(posedge clk) disable iff (!rstn)
      halted && irq_rise |=> !(mode_r inside {CMT_STOP, CMT_WAIT}) ##1 cpu_clk_run_r;
   endproperty
   a_wake: assert property (p_wake) else $error("interrupt did not wake"); // RULE_12

   // A wait refused beside an accepted write may still see the write move state
   property p_refused_hold;
      @(posedge clk) disable iff (!rstn)
      refused_r && !$past(wake) && !$past(wr_ok) |-> $stable(mode_r) && $stable(ctrl_r);
   endproperty
   a_refused_hold: assert property (p_refused_hold) else $error("refused request changed state"); // RULE_15

   property p_div_code;
      @(posedge clk) disable iff (!rstn)
      !ctrl_r.div8_force_bit && {ctrl_r.cpu_div_select_hi, ctrl_r.cpu_div_select_lo} == `CMT_DSEL_16 |=>
         cpu_div_ratio_r == `CMT_RATIO_16;
   endproperty
   a_div_code: assert property (p_div_code) else $error("divide-by-16 code wrong"); // RULE_13
endmodule

// *** testbench.sv ***
// Self-checking bench for the clock operating-mode sequencer
`include "cmt_consts.svh"
module testbench import cmt_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;

   // One row: control word written, mode expected, whether it is accepted
   typedef struct packed {
      logic [10:0] d;
      cmt_mode_e   m;
      logic        acc;
   } cmt_row_s;

   logic       clk;          // 250 MHz clock
   logic       rstn;         // Active-low reset
   logic       ctrl_wr;      // Control write strobe
   cmt_ctrl_s  ctrl_wdata;   // Control word written
   logic       wait_instr;   // Wait instruction pulse
   logic       hw_irq;       // Wake interrupt level
   cmt_mode_e  mode_r;       // Mode in force
   cmt_ctrl_s  ctrl_r;       // Control word in force
   logic [4:0] ratio;        // Divider ratio
   logic       run;          // CPU clock running
   logic       sub_en;       // Sub clock to timers
   logic       refused_r;    // Ignored request pulse
   logic [3:0] gate;         // One-hot source gate
   int         err_count;    // Mismatches
   int         checks;       // Comparisons made
   cmt_mode_e  exp_mode;     // Predicted mode
   cmt_ctrl_s  exp_ctrl;     // Predicted control word

   // Ordinary transitions from reset onward
   cmt_row_s rows [26] = '{
      '{11'h000, CMT_HMS, 1'b1}, '{11'h004, CMT_HMS, 1'b1}, '{11'h008, CMT_HMS, 1'b1},
      '{11'h00c, CMT_HMS, 1'b1}, '{11'h200, CMT_HMS, 1'b1}, '{11'h040, CMT_LOWSPD, 1'b0},
      '{11'h080, CMT_HMS, 1'b1}, '{11'h0c0, CMT_LOWSPD, 1'b1}, '{11'h011, CMT_PLL, 1'b0},
      '{11'h1c0, CMT_LOWPWR, 1'b1}, '{11'h080, CMT_HMS, 1'b0}, '{11'h082, CMT_OCO, 1'b0},
      '{11'h0c0, CMT_LOWSPD, 1'b1}, '{11'h080, CMT_HMS, 1'b1}, '{11'h091, CMT_PLL, 1'b1},
      '{11'h082, CMT_OCO, 1'b0}, '{11'h011, CMT_PLL, 1'b1}, '{11'h000, CMT_HMS, 1'b1},
      '{11'h082, CMT_OCO, 1'b1}, '{11'h0c0, CMT_LOWSPD, 1'b1}, '{11'h082, CMT_OCO, 1'b1},
      '{11'h182, CMT_OCO_LP, 1'b1}, '{11'h080, CMT_HMS, 1'b0}, '{11'h0c0, CMT_LOWSPD, 1'b0},
      '{11'h282, CMT_OCO, 1'b1}, '{11'h280, CMT_HMS, 1'b1}};

   cmt_ctrl cmt_ctrl_i (
      .clk                (clk),
      .rstn               (rstn),
      .ctrl_wr            (ctrl_wr),
      .ctrl_wdata         (ctrl_wdata),
      .wait_instr         (wait_instr),
      .hw_irq             (hw_irq),
      .mode_r             (mode_r),
      .ctrl_r             (ctrl_r),
      .cpu_div_ratio_r    (ratio),
      .cpu_clk_run_r      (run),
      .sub_timer_clk_en_r (sub_en),
      .refused_r          (refused_r),
      .src_gate_r         (gate)
   );

   // Clock generator
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   // Ratio expected from a control word
   function automatic logic [4:0] ratio_of(input cmt_ctrl_s c);
      if (c.div8_force_bit) return `CMT_RATIO_8;
      case ({c.cpu_div_select_hi, c.cpu_div_select_lo})
         `CMT_DSEL_1: return `CMT_RATIO_1;
         `CMT_DSEL_2: return `CMT_RATIO_2;
         `CMT_DSEL_4: return `CMT_RATIO_4;
         default:     return `CMT_RATIO_16;
      endcase
   endfunction

   // Gate expected from mode and selection bits
   function automatic logic [3:0] gate_of(input cmt_mode_e m, input cmt_ctrl_s c);
      if (m == CMT_STOP) return `CMT_SRC_NONE;
      if (c.sysclk_sub_select) return `CMT_SRC_SUB;
      if (c.onchip_osc_select) return `CMT_SRC_ONCHIP;
      if (c.pll_enable_bit && c.pll_route_select) return `CMT_SRC_PLL;
      return `CMT_SRC_MAIN;
   endfunction

   task automatic bad(input string what);
      err_count++;
      $display("unexpected at %0t: %s", $time, what);
   endtask

   task automatic cmp_mode(input cmt_mode_e got, input cmt_mode_e exp);
      checks++;
      if (got !== exp) bad($sformatf("mode %0d want %0d", got, exp));
   endtask

   task automatic cmp_ctrl(input cmt_ctrl_s got, input cmt_ctrl_s exp);
      checks++;
      if (got !== exp) bad($sformatf("ctrl %h want %h", got, exp));
   endtask

   task automatic cmp_vec(input logic [4:0] got, input logic [4:0] exp, input string what);
      checks++;
      if (got !== exp) bad($sformatf("%s %h want %h", what, got, exp));
   endtask

   // Check of every output but refused_r against the predicted state
   task automatic chk();
      cmp_mode(mode_r, exp_mode);
      cmp_ctrl(ctrl_r, exp_ctrl);
      cmp_vec(ratio, ratio_of(exp_ctrl), "ratio");
      cmp_vec({1'b0, gate}, {1'b0, gate_of(exp_mode, exp_ctrl)}, "gate");
      cmp_vec({4'h0, run}, {4'h0, exp_mode != CMT_STOP && exp_mode != CMT_WAIT}, "run");
      cmp_vec({4'h0, sub_en}, {4'h0, exp_ctrl.sub_osc_on_bit && exp_mode != CMT_STOP}, "sub");
   endtask

   // Pulse one request, look for the refusal pulse, then settle and check
   task automatic req(input logic wr, input logic [10:0] d, input cmt_mode_e m, input logic acc);
      logic      seen;   // Refusal pulse seen
      cmt_ctrl_s w;      // Requested word as fields
      w = cmt_ctrl_s'(d);
      ctrl_wr = wr;
      wait_instr = !wr;
      ctrl_wdata = cmt_ctrl_s'(d);
      @(negedge clk);
      ctrl_wr = 1'b0;
      wait_instr = 1'b0;
      seen = refused_r;
      @(negedge clk);
      seen = seen | refused_r;
      cmp_vec({4'h0, seen}, {4'h0, !acc}, "refused");
      if (acc) begin
         exp_mode = m;
         // Stop word keeps the other bits; main stop forces divide-by-8
         if (wr && w.stop_entry_bit) exp_ctrl = exp_ctrl | 11'h020;
         else if (wr) exp_ctrl = cmt_ctrl_s'(d | (w.main_osc_stop_bit ? 11'h200 : 11'h000));
      end
      repeat (8) @(negedge clk);
      chk();
   endtask

   // Raise the interrupt and expect the prior mode back
   task automatic wake(input cmt_mode_e m);
      if (exp_mode == CMT_STOP) exp_ctrl = (exp_ctrl | 11'h200) & 11'h7df;
      exp_mode = m;
      hw_irq = 1'b1;
      repeat (6) @(negedge clk);
      hw_irq = 1'b0;
      repeat (6) @(negedge clk);
      chk();
   endtask

   task automatic end_sim();
      $display("checks %0d err_count %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      #40000;
      bad("watchdog expired");
      end_sim();
   end

   // Main sequence
   initial begin
      err_count = 0;
      checks = 0;
      rstn = 1'b0;
      ctrl_wr = 1'b0;
      ctrl_wdata = cmt_ctrl_s'(11'h000);
      wait_instr = 1'b0;
      hw_irq = 1'b0;
      exp_mode = CMT_HMS;
      exp_ctrl = cmt_ctrl_s'(`CMT_CTRL_RST);
      repeat (20) @(negedge clk);
      chk();
      rstn = 1'b1;
      @(negedge clk);
      chk();
      // Transition matrix rows; stop-detect enable stays clear, divide-by-8 set before on-chip to high-speed
      foreach (rows[i]) req(1'b1, rows[i].d, rows[i].m, rows[i].acc);
      // Stop entry, refusals while halted, wake forces divide-by-8
      req(1'b1, 11'h080, CMT_HMS, 1'b1);
      req(1'b1, 11'h0a0, CMT_STOP, 1'b1);
      req(1'b1, 11'h000, CMT_STOP, 1'b0);
      req(1'b0, 11'h000, CMT_STOP, 1'b0);
      wake(CMT_HMS);
      // Wait entry and wake keep the word
      req(1'b0, 11'h000, CMT_WAIT, 1'b1);
      wake(CMT_HMS);
      // Interrupt outside a halt is ignored
      wake(CMT_HMS);
      // Stop from low power returns to low power
      req(1'b1, 11'h0c0, CMT_LOWSPD, 1'b1);
      req(1'b1, 11'h1c0, CMT_LOWPWR, 1'b1);
      req(1'b1, 11'h1e0, CMT_STOP, 1'b1);
      wake(CMT_LOWPWR);
      req(1'b1, 11'h0c0, CMT_LOWSPD, 1'b1);
      // No stop or wait from PLL
      req(1'b1, 11'h080, CMT_HMS, 1'b1);
      req(1'b1, 11'h091, CMT_PLL, 1'b1);
      req(1'b0, 11'h000, CMT_PLL, 1'b0);
      req(1'b1, 11'h0b1, CMT_PLL, 1'b0);
      req(1'b1, 11'h080, CMT_HMS, 1'b1);
      // Reset in mid-run restores defaults
      req(1'b1, 11'h0c0, CMT_LOWSPD, 1'b1);
      rstn = 1'b0;
      exp_mode = CMT_HMS;
      exp_ctrl = cmt_ctrl_s'(`CMT_CTRL_RST);
      repeat (3) @(negedge clk);
      chk();
      rstn = 1'b1;
      @(negedge clk);
      chk();
      end_sim();
   end
endmodule
